/* core/dbgtap_pkg.sv */
package dbgtap_pkg;

  // JTAG TAP states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET     = 16'h0001,
    TAP_IDLE      = 16'h0002,
    TAP_SEL_DR    = 16'h0004,
    TAP_CAP_DR    = 16'h0008,
    TAP_SHIFT_DR  = 16'h0010,
    TAP_EXIT1_DR  = 16'h0020,
    TAP_PAUSE_DR  = 16'h0040,
    TAP_EXIT2_DR  = 16'h0080,
    TAP_UPD_DR    = 16'h0100,
    TAP_SEL_IR    = 16'h0200,
    TAP_CAP_IR    = 16'h0400,
    TAP_SHIFT_IR  = 16'h0800,
    TAP_EXIT1_IR  = 16'h1000,
    TAP_PAUSE_IR  = 16'h2000,
    TAP_EXIT2_IR  = 16'h4000,
    TAP_UPD_IR    = 16'h8000
  } dbgtap_tap_state_t;

  // Core run state, one-hot
  typedef enum logic [2:0] {
    CORE_RUN    = 3'h1,
    CORE_DRAIN  = 3'h2,
    CORE_HALTED = 3'h4
  } dbgtap_core_state_t;

  localparam int IR_W = 4;
  localparam int DR_W = 17;
  localparam logic [IR_W-1:0] IR_RESET = 4'h1;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_DEBUG_DR = 4'h8;
  localparam int PKT_W = 17;
  localparam logic [3:0] PST_HALT = 4'hf;
  localparam logic [3:0] PST_IDLE = 4'h0;
  localparam logic [3:0] PST_EXEC = 4'h1;
  localparam logic [1:0] SYNC_STAGES = 2'h2;
  localparam int DSYNC_POS_RELEASE = 16;

  // JTAG pin bundle
  typedef struct packed {
    logic tms;
    logic tdi;
  } dbgtap_jtag_in_t;

  // Core side status and controls
  typedef struct packed {
    logic instr_done;
    logic brk_disable;
    logic resume;
  } dbgtap_core_in_t;

  typedef struct packed {
    logic halted;
    logic dbg_irq;
    logic [3:0] pst;
  } dbgtap_core_out_t;

endpackage : dbgtap_pkg

/* core/dbgtap_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module dbgtap_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_r <= d_i;
      q_o <= s1_r;
    end
  end
endmodule : dbgtap_sync2
`default_nettype wire

/* core/dbgtap_tap.sv */
`timescale 1ns/100ps
`default_nettype none
module dbgtap_tap
  import dbgtap_pkg::*;
(
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire dbgtap_pkg::dbgtap_jtag_in_t jtag_i,
  input wire logic enable_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  dbgtap_tap_state_t st_r;
  dbgtap_tap_state_t st_nxt;
  logic [IR_W-1:0] ir_shift_r;
  logic [IR_W-1:0] ir_r;
  logic [DR_W-1:0] dr_shift_r;
  logic bypass_r;
  logic tms;
  logic serial_bit;

  assign tms = jtag_i.tms | ~enable_i;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      TAP_RESET: st_nxt = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: st_nxt = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: st_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: st_nxt = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: st_nxt = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: st_nxt = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: st_nxt = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: st_nxt = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: st_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: st_nxt = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: st_nxt = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: st_nxt = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: st_nxt = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: st_nxt = tms ? TAP_SEL_DR : TAP_IDLE;
      default: st_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      st_r <= TAP_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_shift_r <= '0;
      ir_r <= IR_RESET;
      dr_shift_r <= '0;
      bypass_r <= 1'b0;
    end else begin
      if (st_r == TAP_RESET) begin
        ir_r <= IR_RESET;
      end else if (st_r == TAP_CAP_IR) begin
        ir_shift_r <= IR_CAPTURE;
      end else if (st_r == TAP_SHIFT_IR) begin
        ir_shift_r <= {jtag_i.tdi, ir_shift_r[IR_W-1:1]};
      end else if (st_r == TAP_UPD_IR) begin
        ir_r <= ir_shift_r;
      end
      if (st_r == TAP_CAP_DR) begin
        bypass_r <= 1'b0;
      end else if (st_r == TAP_SHIFT_DR) begin
        bypass_r <= jtag_i.tdi;
        dr_shift_r <= {jtag_i.tdi, dr_shift_r[DR_W-1:1]};
      end
    end
  end

  always_comb begin
    if (st_r == TAP_SHIFT_IR) begin
      serial_bit = ir_shift_r[0];
    end else if (ir_r == IR_DEBUG_DR) begin
      serial_bit = dr_shift_r[0];
    end else begin
      serial_bit = bypass_r;
    end
  end

  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= serial_bit;
      tdo_oe_o <= (st_r == TAP_SHIFT_IR) || (st_r == TAP_SHIFT_DR);
    end
  end
endmodule : dbgtap_tap
`default_nettype wire

/* core/dbgtap_top.sv */
// Summary of operation
// - The debug port select level captured at reset chooses serial debug or JTAG on the pins.
// - A low test reset puts the TAP logic into its reset state at once, with no clock edge.
// - TMS steps the TAP and TDI feeds the shift registers, both on rising test clock edges.
// - TDO is enabled only in the Shift-IR and Shift-DR states.
// - TDO is updated only on falling test clock edges.
// - A new serial debug clock level counts only after two equal bus clock samples.
// - At each validated serial clock rise in serial debug mode the serial input is sampled and the output moves.
// - A breakpoint request lets the current instruction finish and then halts the core.
// - While halted the processor status lines show 0xf.
// - With breakpoint disable set, a request raises a debug interrupt instead of a halt.
// - The serial debug output comes from a register and moves after the clock high is seen.
// - Status lines are registered on the processor clock, independent of bus transfers.
`timescale 1ns/100ps
`default_nettype none
module dbgtap_top
  import dbgtap_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic TEST_CLOCK_I,
  input wire logic TRST_N_I,
  input wire logic JTAG_SELECT_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  input wire logic DEBUG_SERIAL_CLOCK_I,
  input wire logic DEBUG_SERIAL_IN_I,
  input wire logic BREAKPOINT_REQUEST_N_I,
  input wire logic INSTR_DONE_I,
  input wire logic BREAKPOINT_DISABLE_BIT_I,
  input wire logic RESUME_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  output logic DEBUG_SERIAL_OUT_O,
  output logic [3:0] PROCESSOR_STATUS_LINES_O,
  output logic HALTED_O,
  output logic DEBUG_IRQ_O,
  output logic [PKT_W-1:0] DEBUG_PKT_O,
  output logic DEBUG_PKT_VALID_O
);
  import dbgtap_pkg::*;

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  logic jtag_sel_sync;
  logic jtag_mode_r;
  logic [1:0] sel_cnt_r;
  logic tap_tdo;
  logic tap_oe;
  logic debug_serial_clock_sync;
  logic debug_serial_clock_cand_r;
  logic debug_serial_clock_valid_r;
  logic debug_serial_clock_prev_r;
  logic dsi_sync;
  logic breakpoint_request_n_sync;
  logic breakpoint_request_prev_r;
  logic breakpoint_request_evt;
  logic [PKT_W-1:0] rx_sh_r;
  logic [PKT_W-1:0] tx_sh_r;
  logic [4:0] bit_cnt_r;
  logic ds_rise;
  dbgtap_jtag_in_t jtag_in;
  dbgtap_core_state_t core_st_r;
  dbgtap_core_state_t core_st_nxt;

  dbgtap_sync2 u_sync_sel (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(JTAG_SELECT_I),
    .q_o(jtag_sel_sync)
  );

  // latch select at reset release
  // Wait until the synchroniser holds the pin level, not its reset value
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sel_cnt_r <= 2'h0;
      jtag_mode_r <= 1'b0;
    end else if (sel_cnt_r < SYNC_STAGES) begin
      sel_cnt_r <= sel_cnt_r + 2'h1;
    end else if (sel_cnt_r == SYNC_STAGES) begin
      sel_cnt_r <= sel_cnt_r + 2'h1;
      jtag_mode_r <= jtag_sel_sync;
    end
  end

  assign jtag_in.tms = TMS_I;
  assign jtag_in.tdi = TDI_I;

  // Mode select is static after reset, so it feeds the TAP domain directly
  dbgtap_tap u_tap (
    .tck_i(TEST_CLOCK_I),
    .trst_n_i(TRST_N_I),
    .jtag_i(jtag_in),
    .enable_i(jtag_mode_r),
    .tdo_o(tap_tdo),
    .tdo_oe_o(tap_oe)
  );

  assign TDO_O = tap_tdo;
  assign TDO_OE_O = tap_oe;

  dbgtap_sync2 u_sync_debug_serial_clock (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(DEBUG_SERIAL_CLOCK_I),
    .q_o(debug_serial_clock_sync)
  );

  dbgtap_sync2 u_sync_dsi (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(DEBUG_SERIAL_IN_I),
    .q_o(dsi_sync)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      debug_serial_clock_cand_r <= 1'b0;
      debug_serial_clock_valid_r <= 1'b0;
      debug_serial_clock_prev_r <= 1'b0;
    end else begin
      debug_serial_clock_cand_r <= debug_serial_clock_sync;
      if (debug_serial_clock_cand_r == debug_serial_clock_sync) begin
        debug_serial_clock_valid_r <= debug_serial_clock_sync;
      end
      debug_serial_clock_prev_r <= debug_serial_clock_valid_r;
    end
  end

  // Serial port is idle while the pins serve JTAG
  assign ds_rise = rise(debug_serial_clock_valid_r, debug_serial_clock_prev_r) & ~jtag_mode_r;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_sh_r <= '0;
      tx_sh_r <= '0;
      bit_cnt_r <= '0;
      DEBUG_SERIAL_OUT_O <= 1'b0;
      DEBUG_PKT_O <= '0;
      DEBUG_PKT_VALID_O <= 1'b0;
    end else begin
      DEBUG_PKT_VALID_O <= 1'b0;
      if (ds_rise) begin
        rx_sh_r <= {rx_sh_r[PKT_W-2:0], dsi_sync};
        DEBUG_SERIAL_OUT_O <= tx_sh_r[PKT_W-1];
        if (bit_cnt_r == 5'(PKT_W - 1)) begin
          bit_cnt_r <= '0;
          DEBUG_PKT_O <= {rx_sh_r[PKT_W-2:0], dsi_sync};
          DEBUG_PKT_VALID_O <= 1'b1;
          // Response echoes core halt state in its status bit
          tx_sh_r <= {1'b0, 15'h0000, core_st_r == CORE_HALTED};
        end else begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
          tx_sh_r <= {tx_sh_r[PKT_W-2:0], 1'b0};
        end
      end
    end
  end

  dbgtap_sync2 u_sync_breakpoint_request (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i(BREAKPOINT_REQUEST_N_I),
    .q_o(breakpoint_request_n_sync)
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // Synchroniser resets to the asserted level, so no false edge follows reset
      breakpoint_request_prev_r <= 1'b1;
    end else begin
      breakpoint_request_prev_r <= ~breakpoint_request_n_sync;
    end
  end

  assign breakpoint_request_evt = rise(~breakpoint_request_n_sync, breakpoint_request_prev_r);

  always_comb begin
    core_st_nxt = core_st_r;
    case (core_st_r)
      CORE_RUN: begin
        if (breakpoint_request_evt && !BREAKPOINT_DISABLE_BIT_I) begin
          core_st_nxt = INSTR_DONE_I ? CORE_HALTED : CORE_DRAIN;
        end
      end
      CORE_DRAIN: begin
        if (INSTR_DONE_I) begin
          core_st_nxt = CORE_HALTED;
        end
      end
      CORE_HALTED: begin
        if (RESUME_I) begin
          core_st_nxt = CORE_RUN;
        end
      end
      default: core_st_nxt = CORE_RUN;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      core_st_r <= CORE_RUN;
    end else begin
      core_st_r <= core_st_nxt;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DEBUG_IRQ_O <= 1'b0;
    end else begin
      DEBUG_IRQ_O <= breakpoint_request_evt && BREAKPOINT_DISABLE_BIT_I && (core_st_r == CORE_RUN);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PROCESSOR_STATUS_LINES_O <= PST_IDLE;
      HALTED_O <= 1'b0;
    end else begin
      HALTED_O <= core_st_nxt == CORE_HALTED;
      if (core_st_nxt == CORE_HALTED) begin
        PROCESSOR_STATUS_LINES_O <= PST_HALT;
      end else if (INSTR_DONE_I) begin
        PROCESSOR_STATUS_LINES_O <= PST_EXEC;
      end else begin
        PROCESSOR_STATUS_LINES_O <= PST_IDLE;
      end
    end
  end
endmodule : dbgtap_top
`default_nettype wire

/* testbench/dbgtap_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module dbgtap_chk
  import dbgtap_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic TEST_CLOCK_I,
  input wire logic TRST_N_I,
  input wire logic TMS_I,
  input wire logic DEBUG_SERIAL_CLOCK_I,
  input wire logic BREAKPOINT_REQUEST_N_I,
  input wire logic INSTR_DONE_I,
  input wire logic BREAKPOINT_DISABLE_BIT_I,
  input wire logic RESUME_I,
  input wire logic TDO_OE_O,
  input wire logic DEBUG_SERIAL_OUT_O,
  input wire logic [3:0] PROCESSOR_STATUS_LINES_O,
  input wire logic HALTED_O,
  input wire logic DEBUG_IRQ_O
);
  sequence s_req;
    $fell(BREAKPOINT_REQUEST_N_I) && !HALTED_O;
  endsequence
  sequence s_clk_held;
    $past(DEBUG_SERIAL_CLOCK_I, 3) ##0 $past(DEBUG_SERIAL_CLOCK_I, 2);
  endsequence
  property p_sync;
    @(posedge CLK_I) disable iff (RST_I) s_req |=> !HALTED_O && !DEBUG_IRQ_O;
  endproperty
  a_sync: assert property (p_sync) else $error("request acted on unsynchronised");
  property p_halt_pst;
    @(posedge CLK_I) disable iff (RST_I) HALTED_O |-> PROCESSOR_STATUS_LINES_O == PST_HALT;
  endproperty
  a_halt_pst: assert property (p_halt_pst) else $error("halt status not shown");
  property p_halt_done;
    @(posedge CLK_I) disable iff (RST_I) $rose(HALTED_O) |-> $past(INSTR_DONE_I);
  endproperty
  a_halt_done: assert property (p_halt_done) else $error("halt before instruction end");
  property p_resume;
    @(posedge CLK_I) disable iff (RST_I) $fell(HALTED_O) |-> $past(RESUME_I) || $past(RESUME_I, 2);
  endproperty
  a_resume: assert property (p_resume) else $error("halt left without resume");
  property p_irq;
    @(posedge CLK_I) disable iff (RST_I)
      DEBUG_IRQ_O |-> $past(BREAKPOINT_DISABLE_BIT_I) && !HALTED_O ##1 !DEBUG_IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("debug interrupt misplaced");
  property p_exec;
    @(posedge CLK_I) disable iff (RST_I) PROCESSOR_STATUS_LINES_O == PST_EXEC |-> $past(INSTR_DONE_I);
  endproperty
  a_exec: assert property (p_exec) else $error("status not tied to clock");
  property p_dso;
    @(posedge CLK_I) disable iff (RST_I) $changed(DEBUG_SERIAL_OUT_O) |-> s_clk_held;
  endproperty
  a_dso: assert property (p_dso) else $error("serial out moved early");
  property p_oe_off;
    @(posedge TEST_CLOCK_I) disable iff (!TRST_N_I) TDO_OE_O && TMS_I |=> !TDO_OE_O;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("TDO driven outside shift");
  property p_trst;
    @(posedge CLK_I) disable iff (RST_I) !TRST_N_I |-> !TDO_OE_O;
  endproperty
  a_trst: assert property (p_trst) else $error("TDO driven in test reset");
endmodule : dbgtap_chk
bind dbgtap_top dbgtap_chk i_dbgtap_chk (.CLK_I, .RST_I, .TEST_CLOCK_I, .TRST_N_I, .TMS_I,
  .DEBUG_SERIAL_CLOCK_I, .BREAKPOINT_REQUEST_N_I, .INSTR_DONE_I, .BREAKPOINT_DISABLE_BIT_I,
  .RESUME_I, .TDO_OE_O, .DEBUG_SERIAL_OUT_O, .PROCESSOR_STATUS_LINES_O, .HALTED_O,
  .DEBUG_IRQ_O);
`default_nettype wire

/* testbench/dbgtap_probe.sv */
`timescale 1ns/100ps
`default_nettype none
module dbgtap_probe (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic debug_serial_clock_o,
  output logic dsi_o,
  input wire logic tdo_i,
  input wire logic dso_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    debug_serial_clock_o = 1'b0;
    dsi_o = 1'b0;
  end
  // Test clock only runs inside a step; TDO read 5 ns into the 15 ns high phase
  task automatic tstep(input logic tms_v, input logic tdi_v, output logic tdo_v);
    tms_o = tms_v;
    tdi_o = tdi_v;
    #15 tck_o = 1'b1;
    #5 tdo_v = tdo_i;
    #10 tck_o = 1'b0;
  endtask : tstep
  task automatic send_pkt(input logic [16:0] tx, output logic [16:0] rx);
    for (int i = 16; i >= 0; i--) begin
      dsi_o = tx[i];
      #20 debug_serial_clock_o = 1'b1;
      #60 rx[i] = dso_i;
      debug_serial_clock_o = 1'b0;
      #40;
    end
    // Released data line must not look like a held bit
    dsi_o = ~dsi_o;
  endtask : send_pkt
endmodule : dbgtap_probe
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dbgtap_pkg::*;
  logic clk = 1'b0, rst = 1'b1, trst_n = 1'b1, sel = 1'b0, brk_n = 1'b1;
  logic done = 1'b0, breakpoint_disable_bit = 1'b0, resume = 1'b0;
  logic tck, tms, tdi, debug_serial_clock, dsi, tdo, oe, debug_serial_out, halted, irq, pv, b;
  logic [3:0] pst;
  logic [16:0] pkt, rx;
  int err_total = 0, n_tests = 0, cyc = 0, n_irq = 0, n_pv = 0;
  dbgtap_top i_dbgtap_top (.CLK_I(clk), .RST_I(rst), .TEST_CLOCK_I(tck), .TRST_N_I(trst_n),
    .JTAG_SELECT_I(sel), .TMS_I(tms), .TDI_I(tdi), .DEBUG_SERIAL_CLOCK_I(debug_serial_clock),
    .DEBUG_SERIAL_IN_I(dsi), .BREAKPOINT_REQUEST_N_I(brk_n), .INSTR_DONE_I(done),
    .BREAKPOINT_DISABLE_BIT_I(breakpoint_disable_bit), .RESUME_I(resume), .TDO_O(tdo), .TDO_OE_O(oe),
    .DEBUG_SERIAL_OUT_O(debug_serial_out), .PROCESSOR_STATUS_LINES_O(pst), .HALTED_O(halted),
    .DEBUG_IRQ_O(irq), .DEBUG_PKT_O(pkt), .DEBUG_PKT_VALID_O(pv));
  dbgtap_probe i_dbgtap_probe (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .debug_serial_clock_o(debug_serial_clock),
    .dsi_o(dsi), .tdo_i(tdo), .dso_i(debug_serial_out));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    n_irq += (irq === 1'b1);
    n_pv += (pv === 1'b1);
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [16:0] g, input logic [16:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic do_reset(input logic s);
    sel = s;
    rst = 1'b1;
    #1 trst_n = 1'b0;
    wt(5);
    rst = 1'b0;
    trst_n = 1'b1;
    wt(5);
  endtask : do_reset
  task automatic pulse_done;
    done = 1'b1;
    wt(1);
    done = 1'b0;
    wt(1);
  endtask : pulse_done
  task automatic t_halt;
    brk_n = 1'b0;
    wt(6);
    chk(17'(halted), 17'h0);
    pulse_done();
    chk(17'(halted), 17'h1);
    chk(17'(pst), 17'(PST_HALT));
    brk_n = 1'b1;
  endtask : t_halt
  task automatic t_serial;
    i_dbgtap_probe.send_pkt(17'h1a5c3, rx);
    wt(8);
    chk(pkt, 17'h1a5c3);
    chk(17'(n_pv), 17'h1);
    i_dbgtap_probe.send_pkt(17'h00001, rx);
    wt(8);
    chk(17'($countones(rx)), 17'h1);
    resume = 1'b1;
    wt(1);
    resume = 1'b0;
    wt(2);
    chk({16'h0, halted}, 17'h0);
  endtask : t_serial
  task automatic t_irq;
    breakpoint_disable_bit = 1'b1;
    brk_n = 1'b0;
    pulse_done();
    wt(6);
    chk(17'(n_irq), 17'h1);
    chk(17'(halted), 17'h0);
    brk_n = 1'b1;
    breakpoint_disable_bit = 1'b0;
  endtask : t_irq
  task automatic to_shift;
    i_dbgtap_probe.tstep(1'b0, 1'b0, b);
    i_dbgtap_probe.tstep(1'b1, 1'b0, b);
    i_dbgtap_probe.tstep(1'b0, 1'b0, b);
    i_dbgtap_probe.tstep(1'b0, 1'b0, b);
    i_dbgtap_probe.tstep(1'b0, 1'b1, b);
  endtask : to_shift
  task automatic t_jtag;
    to_shift();
    chk(17'(oe), 17'h1);
    i_dbgtap_probe.tstep(1'b0, 1'b0, b);
    chk(17'(b), 17'h1);
    i_dbgtap_probe.tstep(1'b1, 1'b0, b);
    chk(17'(b), 17'h0);
    i_dbgtap_probe.tstep(1'b1, 1'b0, b);
    chk(17'(oe), 17'h0);
    to_shift();
    trst_n = 1'b0;
    #2 chk(17'(oe), 17'h0);
    wt(2);
    trst_n = 1'b1;
  endtask : t_jtag
  initial begin
    do_reset(1'b0);
    t_halt();
    t_serial();
    t_irq();
    to_shift();
    chk(17'(oe), 17'h0);
    do_reset(1'b1);
    t_jtag();
    i_dbgtap_probe.send_pkt(17'h0f0f0, rx);
    wt(8);
    chk(17'(n_pv), 17'h2);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
